// [iea_map.vh]
// Constants for the integer expression datapath
`ifndef IEA_MAP_VH
`define IEA_MAP_VH
`define IEA_W          16
`define IEA_DEPTH      8
`define IEA_OP_W       4
`define IEA_OP_LOAD    4'h0
`define IEA_OP_ADD     4'h1
`define IEA_OP_SUB     4'h2
`define IEA_OP_MUL     4'h3
`define IEA_OP_DIV     4'h4
`define IEA_OP_AND     4'h5
`define IEA_OP_OR      4'h6
`define IEA_OP_XOR     4'h7
`define IEA_OP_OPEN    4'h8
`define IEA_OP_CLOSE   4'h9
`define IEA_OP_RESULT  4'ha
`define IEA_OP_SDEC    4'hb
`define IEA_UN_NONE    3'h0
`define IEA_UN_NEG     3'h1
`define IEA_UN_NOT     3'h2
`define IEA_UN_SQRT    3'h3
`define IEA_UN_W       3
`define IEA_SQRT_STEPS 8
`endif

// [iea_divider.v]
// Restoring unsigned divider, one quotient bit per cycle
`timescale 1ns/10ps
module iea_divider #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_rst_n,
  // Request
  input  wire         i_start,
  input  wire [W-1:0] i_num,
  input  wire [W-1:0] i_den,
  // Answer
  output reg          o_done,
  output reg  [W-1:0] o_quot
);
  reg [W-1:0] rem_q;
  reg [W-1:0] num_q;
  reg [W-1:0] den_q;
  reg [4:0]   cnt_q;
  reg         busy_q;
  wire [W:0]  trial = {rem_q, num_q[W-1]};
  wire [W:0]  diff  = trial - {1'b0, den_q};
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rem_q  <= {W{1'b0}};
      num_q  <= {W{1'b0}};
      den_q  <= {W{1'b0}};
      cnt_q  <= 5'h00;
      busy_q <= 1'b0;
      o_done <= 1'b0;
      o_quot <= {W{1'b0}};
    end else begin
      o_done <= 1'b0;
      if (i_start && !busy_q) begin
        rem_q  <= {W{1'b0}};
        num_q  <= i_num;
        den_q  <= i_den;
        cnt_q  <= W[4:0];
        busy_q <= 1'b1;
      end else if (busy_q) begin
        // Fraction is never formed; quotient is truncated
        if (!diff[W]) begin
          rem_q <= diff[W-1:0];
          num_q <= {num_q[W-2:0], 1'b1};
        end else begin
          rem_q <= trial[W-1:0];
          num_q <= {num_q[W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          busy_q <= 1'b0;
          o_done <= 1'b1;
          // Divide by zero gives all ones, no trap
          o_quot <= diff[W] ? {num_q[W-2:0], 1'b0} : {num_q[W-2:0], 1'b1};
        end
      end
    end
  end
endmodule

// [iea_alu.v]
// Left-to-right integer expression datapath with group stack
// Operation
// - Binary chains run left to right; each result feeds the next step
// - Integer math only; division keeps the truncated whole quotient
// - Groups finish before surrounding work, innermost first
// - Group nesting up to eight levels held in a result stack
// - Unary operator applies to its argument before the binary step
// - All work in 16 bits; narrow operands zero-extended
// - Result for a narrow destination keeps only the low bits
// - Operands are unsigned; division does not handle signed values
// - Negation extends to 16 bits then forms the two's complement
// - Signed decimal formatter reads a zero-extended 16-bit value
// - Every expression, even constant-only, is evaluated at run time
// - Minus is subtraction with two arguments, negation with one
// - Addition wraps modulo 2^16, carry out of bit 15 lost
`timescale 1ns/10ps
`include "iea_map.vh"
module iea_alu #(
  parameter DEPTH = `IEA_DEPTH
) (
  // Clock and reset
  input  wire                  i_ref_clk,
  input  wire                  i_nrst,
  // Operation request from sequencer
  input  wire                  i_req,
  input  wire [`IEA_OP_W-1:0]  i_op,
  input  wire [`IEA_UN_W-1:0]  i_unary,
  input  wire [`IEA_W-1:0]     i_operand,
  input  wire [4:0]            i_src_width,
  input  wire [4:0]            i_dst_width,
  // Answer
  output reg                   o_done,
  output reg  [`IEA_W-1:0]     o_result,
  output reg                   o_sign_neg,
  output reg  [`IEA_W-1:0]     o_sign_mag,
  output reg                   o_error
);
  localparam ST_IDLE = 4'h1;
  localparam ST_SQRT = 4'h2;
  localparam ST_EXEC = 4'h4;
  localparam ST_DIV  = 4'h8;

  reg [1:0]  rst_sync_q;
  wire       rst_n = rst_sync_q[1];
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  reg [3:0]          state_q;
  reg [`IEA_W-1:0]   acc_q;
  reg [`IEA_W-1:0]   arg_q;
  reg [`IEA_OP_W-1:0] op_q;
  reg [4:0]          dstw_q;
  reg [`IEA_W-1:0]   stk_acc [0:DEPTH-1];
  reg [`IEA_OP_W-1:0] stk_op [0:DEPTH-1];
  reg [3:0]          sp_q;
  reg [`IEA_W-1:0]   sq_rem_q;
  reg [`IEA_W-1:0]   sq_root_q;
  reg [`IEA_W-1:0]   sq_bit_q;
  reg [`IEA_OP_W-1:0] pend_q;
  reg                div_start_q;
  wire               div_done;
  wire [`IEA_W-1:0]  div_quot;

  // Zero-extend narrow source operand
  reg [`IEA_W-1:0] ext_op;
  integer k;
  always @* begin
    ext_op = {`IEA_W{1'b0}};
    for (k = 0; k < `IEA_W; k = k + 1)
      if (k < i_src_width || i_src_width == 5'h00) ext_op[k] = i_operand[k];
  end

  // Keep low bits for a narrower destination
  function [`IEA_W-1:0] trunc;
    input [`IEA_W-1:0] v;
    input [4:0]        w;
    integer j;
    begin
      trunc = {`IEA_W{1'b0}};
      for (j = 0; j < `IEA_W; j = j + 1)
        if (j < w || w == 5'h00) trunc[j] = v[j];
    end
  endfunction

  // Unary result before binary use
  reg [`IEA_W-1:0] un_val;
  always @* begin
    case (i_unary)
      `IEA_UN_NEG:  un_val = ~ext_op + 16'h0001; // Full-width negate
      `IEA_UN_NOT:  un_val = ~ext_op;
      default:      un_val = ext_op;
    endcase
  end

  // Binary step: current accumulator is the left operand
  reg [`IEA_W-1:0] bin_val;
  reg [31:0]       prod;
  always @* begin
    prod = acc_q * arg_q;
    case (op_q)
      `IEA_OP_LOAD: bin_val = arg_q;
      `IEA_OP_ADD:  bin_val = acc_q + arg_q; // Carry out dropped
      `IEA_OP_SUB:  bin_val = acc_q - arg_q; // Two-argument minus
      `IEA_OP_MUL:  bin_val = prod[`IEA_W-1:0];
      `IEA_OP_AND:  bin_val = acc_q & arg_q;
      `IEA_OP_OR:   bin_val = acc_q | arg_q;
      `IEA_OP_XOR:  bin_val = acc_q ^ arg_q;
      default:      bin_val = arg_q;
    endcase
  end

  wire [`IEA_W-1:0] sq_try = sq_root_q | sq_bit_q;
  wire stk_full  = (sp_q == DEPTH[3:0]);
  wire stk_empty = (sp_q == 4'h0);

  // Every request is computed here at run time; nothing is folded
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      acc_q       <= {`IEA_W{1'b0}};
      arg_q       <= {`IEA_W{1'b0}};
      op_q        <= `IEA_OP_LOAD;
      pend_q      <= `IEA_OP_LOAD;
      dstw_q      <= 5'h00;
      sp_q        <= 4'h0;
      sq_rem_q    <= {`IEA_W{1'b0}};
      sq_root_q   <= {`IEA_W{1'b0}};
      sq_bit_q    <= {`IEA_W{1'b0}};
      div_start_q <= 1'b0;
      o_done      <= 1'b0;
      o_result    <= {`IEA_W{1'b0}};
      o_sign_neg  <= 1'b0;
      o_sign_mag  <= {`IEA_W{1'b0}};
      o_error     <= 1'b0;
    end else begin
      o_done      <= 1'b0;
      div_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_req && !o_done) begin // One operation at a time
            op_q   <= i_op;
            dstw_q <= i_dst_width;
            arg_q  <= un_val;
            case (i_op)
              `IEA_OP_OPEN: begin
                // Save left side; group restarts from zero
                o_error <= stk_full;
                if (!stk_full) begin
                  stk_acc[sp_q[2:0]] <= acc_q;
                  stk_op[sp_q[2:0]]  <= i_operand[`IEA_OP_W-1:0];
                  sp_q  <= sp_q + 4'h1;
                  acc_q <= {`IEA_W{1'b0}};
                end
                o_done <= 1'b1;
              end
              `IEA_OP_CLOSE: begin
                // Inner group value becomes right operand outside
                o_error <= stk_empty;
                if (!stk_empty) begin
                  arg_q <= acc_q;
                  acc_q <= stk_acc[sp_q[2:0] - 3'h1];
                  op_q  <= stk_op[sp_q[2:0] - 3'h1];
                  sp_q  <= sp_q - 4'h1;
                  state_q <= ST_EXEC;
                end else begin
                  o_done <= 1'b1;
                end
              end
              `IEA_OP_RESULT: begin
                o_result <= trunc(acc_q, i_dst_width);
                o_error  <= 1'b0;
                o_done   <= 1'b1;
              end
              `IEA_OP_SDEC: begin
                // Formatter sees a zero-extended 16-bit value
                o_sign_neg <= ext_op[`IEA_W-1];
                o_sign_mag <= ext_op[`IEA_W-1] ? (~ext_op + 16'h0001) : ext_op;
                o_result   <= ext_op;
                o_error    <= 1'b0;
                o_done     <= 1'b1;
              end
              default: begin
                o_error <= 1'b0;
                if (i_unary == `IEA_UN_SQRT) begin
                  // Square root first, then the binary step
                  sq_rem_q  <= ext_op;
                  sq_root_q <= {`IEA_W{1'b0}};
                  // Start at the top root bit; the step count sets the root width
                  sq_bit_q  <= 16'h0001 << (`IEA_SQRT_STEPS - 1);
                  state_q   <= ST_SQRT;
                end else begin
                  state_q <= ST_EXEC;
                end
              end
            endcase
          end
        end
        ST_SQRT: begin
          // Bitwise integer root; fractional part dropped
          if (sq_try * sq_try <= {16'h0000, sq_rem_q}) sq_root_q <= sq_try;
          sq_bit_q <= {1'b0, sq_bit_q[`IEA_W-1:1]};
          if (sq_bit_q == 16'h0001) begin
            arg_q   <= (sq_try * sq_try <= {16'h0000, sq_rem_q}) ? sq_try : sq_root_q;
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (op_q == `IEA_OP_DIV) begin
            div_start_q <= 1'b1;
            state_q     <= ST_DIV;
          end else begin
            acc_q    <= bin_val; // Intermediate result kept for next step
            o_result <= trunc(bin_val, dstw_q);
            o_done   <= 1'b1;
            state_q  <= ST_IDLE;
          end
        end
        ST_DIV: begin
          if (div_done) begin
            acc_q    <= div_quot; // Truncated quotient, unsigned
            o_result <= trunc(div_quot, dstw_q);
            o_done   <= 1'b1;
            state_q  <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  iea_divider #(
    .W (`IEA_W)
  ) u_div (
    .i_clk   (i_ref_clk),
    .i_rst_n (rst_n),
    .i_start (div_start_q),
    .i_num   (acc_q),
    .i_den   (arg_q),
    .o_done  (div_done),
    .o_quot  (div_quot)
  );
endmodule

// [iea_alu_chk.sv]
// Port checker for the expression datapath
`timescale 1ns/10ps
`include "iea_map.vh"
module iea_alu_chk #(
  parameter DEPTH = 8
) (
  // Clock and reset
  input wire        i_ref_clk,
  input wire        i_nrst,
  // Request and answer
  input wire        i_req,
  input wire [3:0]  i_op,
  input wire [2:0]  i_unary,
  input wire [15:0] i_operand,
  input wire [4:0]  i_src_width,
  input wire [4:0]  i_dst_width,
  input wire        o_done,
  input wire [15:0] o_result,
  input wire        o_sign_neg,
  input wire [15:0] o_sign_mag,
  input wire        o_error
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // Inputs are still held in the done cycle, so they describe the answer
  wire ld = o_done && i_op == `IEA_OP_LOAD;
  wire sd = o_done && i_op == `IEA_OP_SDEC;
  AST_DONE_ONE: assert property (o_done |=> !o_done) else $error("done too long");
  AST_DONE_CAUSE: assert property (o_done |-> $past(i_req)) else $error("done unasked");
  AST_DONE_BOUND: assert property ($rose(i_req) |-> ##[1:50] o_done) else $error("no done");
  AST_LOAD: assert property (ld && i_unary == 3'h0 && i_src_width == 5'h0
    && i_dst_width == 5'h0 |-> o_result == i_operand)
    else $error("load value");
  AST_ZEXT: assert property (ld && i_unary == 3'h0 && i_src_width == 5'h8
    && i_dst_width == 5'h0 |-> o_result == {8'h0, i_operand[7:0]})
    else $error("zero extend");
  AST_TRUNC: assert property (o_done && i_op <= `IEA_OP_XOR && i_dst_width == 5'h8
    |-> o_result[15:8] == 8'h0)
    else $error("truncate");
  AST_NEG: assert property (ld && i_unary == `IEA_UN_NEG && i_src_width == 5'h0
    && i_dst_width == 5'h8 |-> o_result == ((16'h0 - i_operand) & 16'h00ff))
    else $error("negate");
  AST_SDEC: assert property (sd && i_src_width == 5'h0
    |-> o_sign_neg == i_operand[15]
    && o_sign_mag == (i_operand[15] ? 16'h0 - i_operand : i_operand))
    else $error("sdec");
  AST_SDEC_B: assert property (sd && i_src_width == 5'h8 |-> !o_sign_neg
    && o_sign_mag == {8'h0, i_operand[7:0]})
    else $error("sdec byte");
  C_DIV: cover property (o_done && i_op == `IEA_OP_DIV);
  C_CLOSE: cover property (o_done && i_op == `IEA_OP_CLOSE);
  C_ERR: cover property ($rose(o_error));
endmodule
bind iea_alu iea_alu_chk #(.DEPTH(DEPTH)) i_chk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
  .i_req(i_req), .i_op(i_op), .i_unary(i_unary), .i_operand(i_operand),
  .i_src_width(i_src_width), .i_dst_width(i_dst_width), .o_done(o_done),
  .o_result(o_result), .o_sign_neg(o_sign_neg), .o_sign_mag(o_sign_mag), .o_error(o_error));

// [iea_seq_model.sv]
// Sequencer model issuing one held operation at a time
`timescale 1ns/10ps
module iea_seq_model (
  // Clock and answer
  input  wire        i_ref_clk,
  input  wire        i_done,
  // Request
  output reg         o_req,
  output reg  [3:0]  o_op,
  output reg  [2:0]  o_unary,
  output reg  [15:0] o_operand,
  output reg  [4:0]  o_src_width,
  output reg  [4:0]  o_dst_width,
  output reg         o_hung
);
  initial begin
    {o_req, o_op, o_unary, o_operand, o_src_width, o_dst_width, o_hung} = 0;
  end
  task run(input [3:0] c, input [2:0] u, input [15:0] v, input [4:0] s, input [4:0] d);
    integer n;
    begin
      @(negedge i_ref_clk);
      {o_req, o_op, o_unary, o_operand, o_src_width, o_dst_width} = {1'b1, c, u, v, s, d};
      n = 0;
      // Done is looked at mid-cycle, where it has settled
      while (i_done !== 1'b1 && n < 60) begin
        @(negedge i_ref_clk);
        n = n + 1;
      end
      o_hung = (n == 60);
      // Hold through the edge that samples done, then release
      @(negedge i_ref_clk);
      o_req = 1'b0;
      // Released operand flips so a stale value is never mistaken for a held one
      o_operand = ~o_operand;
    end
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the expression datapath
`timescale 1ns/10ps
`include "iea_map.vh"
module tb;
  reg         ref_clk;
  reg         nrst;
  wire        req, done, sneg, err, hung;
  wire [3:0]  op;
  wire [2:0]  un;
  wire [15:0] opd, res, smag;
  wire [4:0]  sw, dw;
  integer     err_total = 0;
  integer     checks_done = 0;
  iea_alu #(.DEPTH(8)) i_dut (.i_ref_clk(ref_clk), .i_nrst(nrst), .i_req(req), .i_op(op),
    .i_unary(un), .i_operand(opd), .i_src_width(sw), .i_dst_width(dw), .o_done(done),
    .o_result(res), .o_sign_neg(sneg), .o_sign_mag(smag), .o_error(err));
  iea_seq_model i_seq (.i_ref_clk(ref_clk), .i_done(done), .o_req(req), .o_op(op),
    .o_unary(un), .o_operand(opd), .o_src_width(sw), .o_dst_width(dw), .o_hung(hung));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task b(input [3:0] c, input [15:0] v);
    i_seq.run(c, 3'h0, v, 5'h0, 5'h0);
  endtask
  task do_reset;
    begin
      nrst = 1'b0;
      repeat (4) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge hung) begin
    err_total = err_total + 1;
    finish_test;
  end
  task t_order;
    begin
      b(`IEA_OP_LOAD, 12);
      b(`IEA_OP_ADD, 3);
      check(res, 15);
      b(`IEA_OP_MUL, 2);
      b(`IEA_OP_DIV, 4);
      check(res, (16'd15 * 16'd2) / 16'd4);
      $display("test order done");
    end
  endtask
  task t_group;
    integer i;
    begin
      b(`IEA_OP_LOAD, 12);
      b(`IEA_OP_OPEN, `IEA_OP_ADD);
      b(`IEA_OP_LOAD, 3);
      b(`IEA_OP_MUL, 2);
      b(`IEA_OP_DIV, 4);
      b(`IEA_OP_CLOSE, 0);
      check(res, 13);
      b(`IEA_OP_LOAD, 100);
      b(`IEA_OP_OPEN, `IEA_OP_DIV);
      b(`IEA_OP_LOAD, 3);
      b(`IEA_OP_MUL, 4);
      b(`IEA_OP_CLOSE, 0);
      check(res, 16'd100 / 16'd12);
      b(`IEA_OP_LOAD, 1);
      for (i = 0; i < 8; i = i + 1) begin
        b(`IEA_OP_OPEN, `IEA_OP_ADD);
        b(`IEA_OP_LOAD, i + 2);
      end
      for (i = 0; i < 8; i = i + 1) b(`IEA_OP_CLOSE, 0);
      check(res, 45);
      check(err, 0);
      for (i = 0; i < 9; i = i + 1) b(`IEA_OP_OPEN, `IEA_OP_ADD);
      check(err, 1);
      do_reset;
      b(`IEA_OP_CLOSE, 0);
      check(err, 1);
      $display("test group done");
    end
  endtask
  task t_unary;
    begin
      b(`IEA_OP_LOAD, 10);
      i_seq.run(`IEA_OP_SUB, `IEA_UN_SQRT, 16, 0, 0);
      check(res, 6);
      i_seq.run(`IEA_OP_LOAD, `IEA_UN_SQRT, 99, 0, 0);
      check(res, 9);
      i_seq.run(`IEA_OP_LOAD, `IEA_UN_NEG, 99, 0, 8);
      check(res, 16'h009d);
      i_seq.run(`IEA_OP_SDEC, 0, 16'h009d, 8, 0);
      check({sneg, smag}, 157);
      i_seq.run(`IEA_OP_SDEC, 0, 16'hfc19, 0, 0);
      check({sneg, smag[14:0]}, 16'h8000 | 999);
      i_seq.run(`IEA_OP_LOAD, 0, 16'hff63, 8, 0);
      check(res, 16'h0063);
      i_seq.run(`IEA_OP_LOAD, `IEA_UN_NOT, 16'hfff1, 8, 8);
      check(res, 16'h000e);
      b(`IEA_OP_LOAD, 16'h1234);
      i_seq.run(`IEA_OP_RESULT, 0, 0, 0, 8);
      check(res, 16'h0034);
      $display("test unary done");
    end
  endtask
  task t_math;
    begin
      b(`IEA_OP_LOAD, 16'hffff);
      b(`IEA_OP_ADD, 2);
      check(res, 1);
      b(`IEA_OP_LOAD, 16'h0 - 1575);
      b(`IEA_OP_ADD, 976);
      check(res, 16'h0 - 599);
      b(`IEA_OP_LOAD, 1000);
      b(`IEA_OP_SUB, 1999);
      check(res, 16'h0 - 999);
      b(`IEA_OP_MUL, 3);
      check(res, 16'h0 - 2997);
      b(`IEA_OP_LOAD, 16'hfffa);
      b(`IEA_OP_DIV, 2);
      check(res, 16'h7ffd);
      b(`IEA_OP_LOAD, 16'h0ff0);
      b(`IEA_OP_AND, 16'h3c3c);
      b(`IEA_OP_OR, 16'h0101);
      b(`IEA_OP_XOR, 16'hffff);
      check(res, ((16'h0ff0 & 16'h3c3c) | 16'h0101) ^ 16'hffff);
      b(`IEA_OP_LOAD, 5);
      b(`IEA_OP_DIV, 0);
      check(res, 16'hffff);
      $display("test math done");
    end
  endtask
  initial begin
    nrst = 1'b0;
    do_reset;
    t_order;
    t_group;
    t_unary;
    t_math;
    finish_test;
  end
endmodule
